// File: design/pcm_pkg.sv
// Shared constants for the companded voice PCM serial link
`default_nettype none
package pcm_pkg;
    // Word layout: polarity, segment and step fields
    localparam int WORD_BITS = 8;
    localparam int SIGN_POS = 7;
    localparam int SEG_MSB = 6;
    localparam int SEG_LSB = 4;
    localparam int STEP_MSB = 3;
    localparam int STEP_LSB = 0;
    localparam int SEG_COUNT = 8;
    // Linear magnitude width and companding constants
    localparam int MAG_W = 13;
    localparam logic [13:0] MAG_BIAS = 14'h0021;
    localparam logic [14:0] MAG_CLIP = 15'h1fde;
    localparam int SEG_BIT_BASE = 5;
    // Word sent when the user offers nothing: positive zero
    localparam logic [7:0] IDLE_WORD = 8'h80;
    // Reset values
    localparam logic [7:0] WORD_RESET = 8'h80;
    localparam logic [3:0] CNT_RESET = 4'h0;
    // Timing: system clock, fastest legal bit clock, frame rate
    localparam int CLK_SYS_KHZ = 125000;
    localparam int BIT_CLK_MAX_KHZ = 2100;
    localparam int FRAME_HZ = 8000;
    // Half period in clk_sys cycles, rounded up so the bit clock stays under its maximum
    localparam int HALF_DIV = (CLK_SYS_KHZ + 2 * BIT_CLK_MAX_KHZ - 1) / (2 * BIT_CLK_MAX_KHZ);
    // Frame repetition period in clk_sys cycles
    localparam int FRAME_CYC = (CLK_SYS_KHZ * 1000) / FRAME_HZ;
    // Least low time of the receive frame pulse, in conversion clocks
    localparam int RX_GAP_CONV = 17;
    // Conversion sequencer, Gray coded from idle to encode; the return to idle flips both bits
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_NULL = 2'b01,
        CONV_ENCODE = 2'b11
    } conv_state_t;
endpackage
`default_nettype wire

// File: design/pcm_link_if.sv
// Serial PCM link between the codec end and the highway controller end
`default_nettype none
interface pcm_link_if;
    logic tx_bit_clock; // Transmit bit clock from controller
    logic tx_frame_pulse; // Transmit frame pulse from controller
    logic tx_data_out; // Codec serial output value
    logic tx_data_oe_n; // Codec output enable, low while driving
    wire logic tx_data_in; // Resolved serial output wire
    logic rx_bit_clock; // Receive bit clock from controller
    logic rx_frame_pulse; // Receive frame pulse from controller
    logic rx_data; // Serial input to the codec
    // Released wire shows the opposite level, so a sample taken outside a frame stands out
    assign tx_data_in = tx_data_oe_n ? ~tx_data_out : tx_data_out;
    modport dev(
        input tx_bit_clock, tx_frame_pulse, rx_bit_clock, rx_frame_pulse, rx_data,
        output tx_data_out, tx_data_oe_n
    );
    modport ctl(
        output tx_bit_clock, tx_frame_pulse, rx_bit_clock, rx_frame_pulse, rx_data,
        input tx_data_in
    );
endinterface
`default_nettype wire

// File: design/codec_serial_end.sv
// Codec end of the PCM link: encoder, transmit shifter, receive shifter, decoder
// Operation
// [R1] Conversions run on master clock, unrelated to link
// [R2] Frame rise enables output, next master edge converts; code enables output at once, starts the null cycle on the third master edge
// [R3] Output bits advance on transmit bit clock rises
// [R4] Output floats while frame low, drives while high
// [R5] Controller may stretch frame, low one master clock
// [R6] Eight-bit word unloaded at bit clock, 64kHz-2.1MHz
// [R7] Late frame rise itself acts as first shift
// [R8] Bits captured on receive clock while frame high
// [R9] Decode starts only after receive frame falls
// [R10] Frame drops before ninth edge, eight bits only
// [R11] Receive frame low seventeen master clocks minimum
// [R12] Late receive frame rise gives first capture edge
// [R13] Word is polarity, 3-bit segment, 4-bit step
// [R14] Eight ascending segments, sixteen steps, doubling sizes
// [R15] Value is base plus steps; polarity one positive
// [R16] Received word uses identical field meanings
// [R17] At 64kHz frames must return low between words
// [R18] Offset adjustment cycle precedes every conversion
// [R19] Frames repeat at 8kHz sampling rate
// [R20] Polarity first, then segment, step, MSB first
`default_nettype none
module codec_serial_end #(
    parameter int MAG_W = pcm_pkg::MAG_W
)(
    input wire logic clk_sys,
    input wire logic nrst,
    pcm_link_if.dev link,
    input wire logic signed [MAG_W:0] adc_sample,
    input wire logic signed [MAG_W:0] adc_zero,
    output logic signed [MAG_W:0] dac_value,
    output logic dac_strobe,
    output logic [7:0] tx_word,
    output logic conv_busy
);
    // Encode a signed linear difference into a companded word
    function automatic logic [7:0] encode(input logic signed [MAG_W+1:0] diff);
        logic neg;
        logic [14:0] mag;
        logic [13:0] biased;
        logic [2:0] seg;
        logic [13:0] stepped;
        neg = diff[MAG_W+1];
        mag = neg ? 15'(-diff) : 15'(diff);
        if (mag > pcm_pkg::MAG_CLIP)
        begin
            mag = pcm_pkg::MAG_CLIP;
        end
        biased = 14'(mag) + pcm_pkg::MAG_BIAS;
        seg = 3'h0;
        // Highest set bit picks the segment; ascending loop lets the top one win
        for (int i = 0; i < pcm_pkg::SEG_COUNT; i++)
        begin
            if (biased[i + pcm_pkg::SEG_BIT_BASE])
            begin
                seg = 3'(i); // R14
            end
        end
        // Four bits wide so that the top segment shifts by eight, not by zero
        stepped = biased >> (4'(seg) + 4'h1);
        // Polarity one means positive; zero difference encodes as positive
        encode = {~neg, seg, stepped[3:0]}; // R13 R15
    endfunction
    // Expand a companded word: base of segment plus steps times step size
    function automatic logic signed [MAG_W:0] decode(input logic [7:0] w);
        logic [13:0] m;
        m = 14'(({9'h000, w[pcm_pkg::STEP_MSB:pcm_pkg::STEP_LSB], 1'b1}
            + 14'h0020) << w[pcm_pkg::SEG_MSB:pcm_pkg::SEG_LSB]) - pcm_pkg::MAG_BIAS; // R14 R15
        decode = w[pcm_pkg::SIGN_POS] ? $signed(m) : -$signed(m); // R15 R16
    endfunction
    // Link domains have no reset: the bit clocks may stop during reset, so a low frame
    // seen by the next bit clock rise clears every counter and flag there instead
    logic [3:0] tx_cnt_reg; // Bits already shifted in this frame
    logic [3:0] rx_cnt_reg; // Bits captured in this frame
    logic [7:0] rx_shift_reg; // Capture shift register
    logic [7:0] rx_word_reg; // Completed word, held until next frame
    logic rx_done_reg; // High from the eighth capture until the frame is seen low
    // Master clock domain
    logic txf_meta; // Transmit frame synchroniser, first stage
    logic txf_sync_reg; // Transmit frame, synchronised
    logic txf_prev_reg; // Previous value for edge detection
    logic rxf_meta; // Receive frame synchroniser, first stage
    logic rxf_sync_reg; // Receive frame, synchronised
    logic rxt_meta; // Word done flag synchroniser, first stage
    logic rxt_sync_reg; // Word done flag, synchronised
    logic rxt_prev_reg; // Previous flag value
    pcm_pkg::conv_state_t conv_state_reg; // Conversion sequencer
    logic signed [MAG_W:0] offset_reg; // Offset caught in the null cycle
    logic [7:0] enc_word_reg; // Freshly encoded word
    logic enc_pending_reg; // Encoded word awaits publication
    logic [7:0] tx_word_reg; // Word shifted out in the next frame
    logic [7:0] rx_hold_reg; // Received word copied into this domain
    logic rx_pending_reg; // Received word awaits decoding
    logic tx_rise; // Transmit frame rising edge seen
    logic rx_word_new; // Receive domain finished a word

    // Transmit bit counter: cleared while frame low, advances on each rising edge up to eight
    always_ff @(posedge link.tx_bit_clock)
    begin
        if (!link.tx_frame_pulse)
        begin
            tx_cnt_reg <= pcm_pkg::CNT_RESET;
        end
        else if (tx_cnt_reg != 4'(pcm_pkg::WORD_BITS))
        begin
            // Saturates so a stretched frame does not wrap into a second word
            tx_cnt_reg <= tx_cnt_reg + 4'h1; // R3 R5 R6
        end
    end

    // First bit is presented at the frame rise itself, before any clock edge,
    // so a late frame rise stands in for the first internal shift edge
    assign link.tx_data_out = (tx_cnt_reg < 4'(pcm_pkg::WORD_BITS))
        ? tx_word_reg[~tx_cnt_reg[2:0]] : 1'b0; // R7 R20
    // Driver follows the frame pulse directly, including its falling edge
    assign link.tx_data_oe_n = ~link.tx_frame_pulse; // R2 R4

    // Receive capture: only while frame high, at most eight bits
    always_ff @(posedge link.rx_bit_clock)
    begin
        if (!link.rx_frame_pulse)
        begin
            rx_cnt_reg <= pcm_pkg::CNT_RESET;
        end
        else if (rx_cnt_reg != 4'(pcm_pkg::WORD_BITS))
        begin
            // A frame raised late is first seen here, which is its first capture
            rx_shift_reg <= {rx_shift_reg[6:0], link.rx_data}; // R8 R12 R20
            rx_cnt_reg <= rx_cnt_reg + 4'h1; // R10
        end
    end

    // Word completion: held word plus a done flag that stands a whole bit period,
    // long enough for the master clock to see it
    always_ff @(posedge link.rx_bit_clock)
    begin
        if (link.rx_frame_pulse && rx_cnt_reg == 4'(pcm_pkg::WORD_BITS - 1))
        begin
            rx_word_reg <= {rx_shift_reg[6:0], link.rx_data}; // R8
            rx_done_reg <= 1'b1;
        end
        else if (!link.rx_frame_pulse)
        begin
            rx_done_reg <= 1'b0;
        end
    end

    // Frame and done flag synchronisers into the master clock domain
    always_ff @(posedge clk_sys)
    begin
        txf_meta <= link.tx_frame_pulse;
        txf_sync_reg <= txf_meta; // R1
        rxf_meta <= link.rx_frame_pulse;
        rxf_sync_reg <= rxf_meta; // R1
        rxt_meta <= rx_done_reg;
        rxt_sync_reg <= rxt_meta; // R1
    end

    // Edge history; the done flag counts as seen, so one left high over reset is no new word
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            txf_prev_reg <= 1'b0;
            rxt_prev_reg <= 1'b1;
        end
        else
        begin
            txf_prev_reg <= txf_sync_reg;
            rxt_prev_reg <= rxt_sync_reg;
        end
    end
    assign tx_rise = txf_sync_reg & ~txf_prev_reg;
    assign rx_word_new = rxt_sync_reg & ~rxt_prev_reg;

    // Conversion sequencer: null cycle, then encode
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            conv_state_reg <= pcm_pkg::CONV_IDLE;
            offset_reg <= '0;
            enc_word_reg <= pcm_pkg::WORD_RESET;
        end
        else
        begin
            case (conv_state_reg)
                // Waits for a transmit frame rise
                pcm_pkg::CONV_IDLE:
                begin
                    if (tx_rise)
                    begin
                        conv_state_reg <= pcm_pkg::CONV_NULL; // R2
                    end
                end
                // Offset adjustment: catch the zero-input level
                pcm_pkg::CONV_NULL:
                begin
                    offset_reg <= adc_zero; // R18
                    conv_state_reg <= pcm_pkg::CONV_ENCODE;
                end
                // Encode the offset-corrected sample
                pcm_pkg::CONV_ENCODE:
                begin
                    enc_word_reg <= encode(
                        (MAG_W+2)'(adc_sample) - (MAG_W+2)'(offset_reg)); // R18
                    conv_state_reg <= pcm_pkg::CONV_IDLE;
                end
                default:
                begin
                    conv_state_reg <= pcm_pkg::CONV_IDLE;
                end
            endcase
        end
    end

    // Publication: the shifted word changes only while the frame is low,
    // so the transmit domain never reads it mid-change
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            enc_pending_reg <= 1'b0;
            tx_word_reg <= pcm_pkg::WORD_RESET;
        end
        else
        begin
            if (enc_pending_reg && !txf_sync_reg && !txf_meta)
            begin
                tx_word_reg <= enc_word_reg; // R5
            end
            // New encode sets pending; set wins over the publish clear
            if (conv_state_reg == pcm_pkg::CONV_ENCODE)
            begin
                enc_pending_reg <= 1'b1;
            end
            else if (!txf_sync_reg && !txf_meta)
            begin
                enc_pending_reg <= 1'b0;
            end
        end
    end

    // Receive word pick-up and decode after the frame has fallen
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rx_hold_reg <= pcm_pkg::WORD_RESET;
            rx_pending_reg <= 1'b0;
            dac_value <= '0;
            dac_strobe <= 1'b0;
        end
        else
        begin
            dac_strobe <= 1'b0;
            if (rx_word_new)
            begin
                // Word is stable: it only changes at the end of the next frame
                rx_hold_reg <= rx_word_reg;
                rx_pending_reg <= 1'b1;
            end
            else if (rx_pending_reg && !rxf_sync_reg)
            begin
                dac_value <= decode(rx_hold_reg); // R9 R16
                dac_strobe <= 1'b1;
                rx_pending_reg <= 1'b0;
            end
        end
    end
    assign tx_word = tx_word_reg;
    assign conv_busy = (conv_state_reg != pcm_pkg::CONV_IDLE);
endmodule
`default_nettype wire

// File: design/pcm_highway_end.sv
// Highway controller end of the PCM link: bit clocks, frame pulses, word exchange
`default_nettype none
module pcm_highway_end #(
    parameter int FRAME_CYC = pcm_pkg::FRAME_CYC,
    parameter int HALF_DIV = pcm_pkg::HALF_DIV
)(
    input wire logic clk_sys,
    input wire logic nrst,
    pcm_link_if.ctl link,
    input wire logic [7:0] send_word,
    input wire logic send_valid,
    output logic send_ready,
    output logic [7:0] got_word,
    output logic got_valid
);
    logic [15:0] div_reg; // Half-period divider
    logic bclk_reg; // Generated bit clock
    logic [15:0] tmr_reg; // Frame repetition timer
    logic due_reg; // Next frame may start
    logic frame_reg; // Frame pulse driven on both directions
    logic [3:0] out_cnt_reg; // Falling edges since frame start
    logic [7:0] out_shift_reg; // Word going to the codec
    logic [3:0] in_cnt_reg; // Bits captured from the codec
    logic [7:0] in_shift_reg; // Word coming from the codec
    logic txd_meta; // Serial input synchroniser, first stage
    logic txd_sync_reg; // Serial input, synchronised
    logic edge_now; // Divider wraps this cycle
    logic rise_now; // Bit clock rises this cycle
    logic fall_now; // Bit clock falls this cycle
    logic start_now; // Frame starts this cycle

    // Bit clock divider; one clock serves both directions
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            div_reg <= 16'h0000;
            bclk_reg <= 1'b0;
        end
        else if (edge_now)
        begin
            div_reg <= 16'h0000;
            bclk_reg <= ~bclk_reg; // R6
        end
        else
        begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    assign edge_now = (div_reg == 16'(HALF_DIV - 1));
    assign rise_now = edge_now & ~bclk_reg;
    assign fall_now = edge_now & bclk_reg;
    assign start_now = fall_now & due_reg & ~frame_reg;
    assign send_ready = start_now;

    // Frame repetition timer
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tmr_reg <= 16'h0000;
            due_reg <= 1'b0;
        end
        else
        begin
            if (tmr_reg == 16'(FRAME_CYC - 1))
            begin
                tmr_reg <= 16'h0000;
                due_reg <= 1'b1; // R19
            end
            else
            begin
                tmr_reg <= tmr_reg + 16'h0001;
                if (start_now)
                begin
                    due_reg <= 1'b0;
                end
            end
        end
    end

    // Frame pulse and outgoing bits change on falling edges
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            frame_reg <= 1'b0;
            out_cnt_reg <= 4'h0;
            out_shift_reg <= pcm_pkg::IDLE_WORD;
        end
        else if (start_now)
        begin
            frame_reg <= 1'b1;
            out_cnt_reg <= 4'h0;
            out_shift_reg <= send_valid ? send_word : pcm_pkg::IDLE_WORD; // R13
        end
        else if (fall_now && frame_reg)
        begin
            if (out_cnt_reg == 4'(pcm_pkg::WORD_BITS - 1))
            begin
                // Drops after eight rises, before the ninth; low for the rest of the period
                frame_reg <= 1'b0; // R5 R10 R11 R17
            end
            else
            begin
                out_shift_reg <= {out_shift_reg[6:0], 1'b0}; // R20
                out_cnt_reg <= out_cnt_reg + 4'h1; // R8
            end
        end
    end

    // Codec serial output, two flip-flops before use
    always_ff @(posedge clk_sys)
    begin
        txd_meta <= link.tx_data_in;
        txd_sync_reg <= txd_meta;
    end

    // Capture the codec's bit just as the clock rises, before it shifts
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            in_cnt_reg <= 4'h0;
            in_shift_reg <= pcm_pkg::WORD_RESET;
            got_word <= pcm_pkg::WORD_RESET;
            got_valid <= 1'b0;
        end
        else
        begin
            got_valid <= 1'b0;
            if (start_now)
            begin
                in_cnt_reg <= 4'h0;
            end
            else if (rise_now && frame_reg && in_cnt_reg != 4'(pcm_pkg::WORD_BITS))
            begin
                in_shift_reg <= {in_shift_reg[6:0], txd_sync_reg}; // R3 R20
                in_cnt_reg <= in_cnt_reg + 4'h1;
                if (in_cnt_reg == 4'(pcm_pkg::WORD_BITS - 1))
                begin
                    got_word <= {in_shift_reg[6:0], txd_sync_reg};
                    got_valid <= 1'b1;
                end
            end
        end
    end

    assign link.tx_bit_clock = bclk_reg;
    assign link.rx_bit_clock = bclk_reg;
    assign link.tx_frame_pulse = frame_reg;
    assign link.rx_frame_pulse = frame_reg;
    assign link.rx_data = out_shift_reg[7];
endmodule
`default_nettype wire

// File: testbench/pcm_link_sva.sv
// Checker for the signals of the serial PCM link
`default_nettype none
module pcm_link_sva #(
    parameter int FRAME_CYC = pcm_pkg::FRAME_CYC,
    parameter int HALF_DIV = pcm_pkg::HALF_DIV
)(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tx_bit_clock,
    input wire logic tx_frame_pulse,
    input wire logic tx_data_out,
    input wire logic tx_data_oe_n,
    input wire logic rx_bit_clock,
    input wire logic rx_frame_pulse,
    input wire logic rx_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int half_cnt; // Cycles since the bit clock last toggled
    int frame_cnt; // Cycles since the last frame start
    logic tog_seen; // First toggle after reset has no reference
    logic frame_seen; // First frame after reset has no reference
    // Interval counters for bit clock and frame rate
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            half_cnt <= 0;
            frame_cnt <= 0;
            tog_seen <= 1'b0;
            frame_seen <= 1'b0;
        end
        else
        begin
            half_cnt <= $changed(tx_bit_clock) ? 0 : half_cnt + 1;
            tog_seen <= tog_seen | $changed(tx_bit_clock);
            frame_cnt <= $rose(tx_frame_pulse) ? 0 : frame_cnt + 1;
            frame_seen <= frame_seen | $rose(tx_frame_pulse);
        end
    end
    // Receive frame: eight bit clocks high, then low
    sequence rx_held;
        rx_frame_pulse [*8] ##1 !rx_frame_pulse;
    endsequence
    // Gap of eight bit clocks, well above seventeen master clocks
    sequence rx_quiet;
        !rx_frame_pulse [*8];
    endsequence
    a_oe_tracks_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
        tx_data_oe_n == !tx_frame_pulse) else $error("output enable off frame");
    a_tx_shift_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(tx_data_out) && tx_frame_pulse && $past(tx_frame_pulse)
        |-> $rose(tx_bit_clock)) else $error("tx bit moved off clock rise");
    a_rx_data_edge: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(rx_data) && rx_frame_pulse && $past(rx_frame_pulse)
        |-> $fell(rx_bit_clock)) else $error("rx bit moved off clock fall");
    a_rx_frame_width: assert property (@(posedge rx_bit_clock) disable iff (!nrst)
        $rose(rx_frame_pulse) |-> rx_held) else $error("rx frame not eight bits");
    a_rx_gap_low: assert property (@(posedge rx_bit_clock) disable iff (!nrst)
        $fell(rx_frame_pulse) |-> rx_quiet) else $error("rx frame gap short");
    a_tx_gap_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(tx_frame_pulse) |-> !tx_frame_pulse [*3]) else $error("tx frame gap short");
    a_frame_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(tx_frame_pulse) && frame_seen |-> frame_cnt >= FRAME_CYC - 2 * HALF_DIV - 1
        && frame_cnt <= FRAME_CYC + 2 * HALF_DIV) else $error("frame period wrong");
    a_bit_half_period: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(tx_bit_clock) && tog_seen |-> half_cnt == HALF_DIV - 1)
        else $error("bit clock half period wrong");
endmodule
`default_nettype wire

// File: testbench/mulaw_pcm_serial_port_bench.sv
// Bench joining the codec end and the highway end over the PCM link
`default_nettype none
`define CHK(a, e) \
    begin \
        n_tests++; \
        if ((a) !== (e)) \
        begin \
            err_count++; \
            $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); \
        end \
    end
module mulaw_pcm_serial_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FC = 1200; // Short frame keeps the run brief
    localparam int HD = 30; // Bit clock just under its maximum
    logic clk_sys = 1'b0; // Highway clock
    logic clk_conv = 1'b0; // Conversion clock, unrelated in phase and rate
    logic nrst = 1'b0;
    logic [7:0] send_word = 8'h00;
    logic send_valid = 1'b0;
    logic signed [13:0] adc_sample = 14'h0000;
    logic signed [13:0] adc_zero = 14'h0000;
    logic signed [13:0] dac_value;
    logic dac_strobe;
    logic [7:0] tx_word;
    logic conv_busy;
    logic send_ready;
    logic [7:0] got_word;
    logic got_valid;
    logic [7:0] tx_wire = 8'h00; // Last eight bits seen on each wire
    logic [7:0] rx_wire = 8'h00;
    int err_count = 0;
    int n_tests = 0;
    always #4 clk_sys = ~clk_sys;
    always #3.7 clk_conv = ~clk_conv;
    pcm_link_if link();
    codec_serial_end i_codec_serial_end (.clk_sys(clk_conv), .nrst(nrst), .link(link),
        .adc_sample(adc_sample), .adc_zero(adc_zero), .dac_value(dac_value),
        .dac_strobe(dac_strobe), .tx_word(tx_word), .conv_busy(conv_busy));
    pcm_highway_end #(.FRAME_CYC(FC), .HALF_DIV(HD)) i_pcm_highway_end (.clk_sys(clk_sys),
        .nrst(nrst), .link(link), .send_word(send_word), .send_valid(send_valid),
        .send_ready(send_ready), .got_word(got_word), .got_valid(got_valid));
    pcm_link_sva #(.FRAME_CYC(FC), .HALF_DIV(HD)) chk (.clk_sys(clk_sys), .nrst(nrst),
        .tx_bit_clock(link.tx_bit_clock), .tx_frame_pulse(link.tx_frame_pulse),
        .tx_data_out(link.tx_data_out), .tx_data_oe_n(link.tx_data_oe_n),
        .rx_bit_clock(link.rx_bit_clock), .rx_frame_pulse(link.rx_frame_pulse),
        .rx_data(link.rx_data));
    // Wire monitors; old values are read before the rise lands
    always @(posedge link.tx_bit_clock)
    begin
        if (link.tx_frame_pulse === 1'b1)
            tx_wire <= {tx_wire[6:0], link.tx_data_in};
        if (link.rx_frame_pulse === 1'b1)
            rx_wire <= {rx_wire[6:0], link.rx_data};
    end
    // Expected word: clip, bias, find segment, take four step bits
    function automatic logic [7:0] enc(input int x);
        int m;
        int b;
        int sg;
        m = (x < 0) ? -x : x;
        if (m > 8158)
            m = 8158;
        b = m + 33;
        sg = 0;
        for (int i = 6; i < 13; i++)
            if (b >= (1 << i))
                sg = i - 5;
        return {x >= 0, sg[2:0], b[sg + 4 -: 4]};
    endfunction
    // Expected value: segment base plus steps, polarity one positive
    function automatic int dec(input logic [7:0] w);
        int m;
        m = ((2 * int'(w[3:0]) + 33) << w[6:4]) - 33;
        return w[7] ? m : -m;
    endfunction
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait: 0 ready, 1 got, 2 busy, 3 strobe
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        do
        begin
            if (sel >= 2)
                @(negedge clk_conv);
            else
                @(negedge clk_sys);
            n++;
        end while (!(sel == 0 ? send_ready === 1'b1 : sel == 1 ? got_valid === 1'b1 :
            sel == 2 ? conv_busy === 1'b1 : dac_strobe === 1'b1) && n < 3000);
        if (n >= 3000)
        begin
            err_count++;
            stop_test();
        end
    endtask
    // Two frames: the second carries the first frame's sample back
    task automatic xfer(input logic [7:0] w, input int s, input int z, input logic v);
        logic [7:0] exp_rx;
        logic [7:0] exp_tx;
        exp_rx = v ? w : pcm_pkg::IDLE_WORD;
        exp_tx = enc(s - z);
        @(negedge clk_sys);
        send_word = w;
        send_valid = v;
        adc_sample = 14'(s);
        adc_zero = 14'(z);
        repeat (2)
        begin
            wait_hi(0);
            wait_hi(2);
            wait_hi(1);
        end
        `CHK(got_word, exp_tx)
        `CHK(tx_word, exp_tx)
        `CHK(tx_wire, exp_tx)
        `CHK(rx_wire, exp_rx)
        wait_hi(3);
        `CHK(link.rx_frame_pulse, 1'b0)
        `CHK(dac_value, 14'(dec(exp_rx)))
    endtask
    // Mid-run reset: outputs return to rest, the output floats
    task automatic reset_check();
        @(negedge clk_sys);
        nrst = 1'b0;
        repeat (5) @(negedge clk_sys);
        `CHK(link.tx_data_oe_n, 1'b1)
        `CHK(tx_word, pcm_pkg::WORD_RESET)
        `CHK(conv_busy, 1'b0)
        `CHK(dac_value, 14'h0000)
        nrst = 1'b1;
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        for (int g = 0; g < 8; g++)
            xfer({g[0], g[2:0], 4'(g * 5)}, (g[0] ? -1 : 1) * ((1 << (g + 5)) + g * 9),
                g * 2, 1'b1);
        xfer(8'h01, -8192, 0, 1'b1);
        xfer(8'h5a, -5, 3, 1'b0);
        reset_check();
        xfer(8'hff, 100, -20, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
